/* File: src/tcc_regs.vh */
// register offsets, field positions and reset values of the 16-bit capture/compare timer
`ifndef TCC_REGS_VH
`define TCC_REGS_VH

`define TCC_OFF_CTRL 12'h000
`define TCC_OFF_PRM 12'h004
`define TCC_OFF_CRC 12'h008
`define TCC_OFF_EDGE 12'h00C
`define TCC_OFF_STAT 12'h010
`define TCC_OFF_CNT 12'h014
`define TCC_OFF_CCA 12'h018
`define TCC_OFF_CCB 12'h01C

`define TCC_CTRL_MODE_LSB 0
`define TCC_CTRL_OS_EN 2
`define TCC_CTRL_OS_TRIG 3
`define TCC_PRM_DIV_LSB 0
`define TCC_PRM_EXT 2
`define TCC_CRC_CAP_A 0
`define TCC_CRC_REV 1
`define TCC_CRC_CAP_B 2
`define TCC_EDGE_A_LSB 0
`define TCC_EDGE_B_LSB 2
`define TCC_STAT_OVF 0
`define TCC_STAT_OUT 1
`define TCC_STAT_RUN 2

`define TCC_MODE_STOP 2'h0
`define TCC_MODE_EDGE_CLR 2'h1
`define TCC_MODE_FREE 2'h2
`define TCC_MODE_MATCH_CLR 2'h3

`define TCC_EDGE_FALL 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_NONE 2'h2
`define TCC_EDGE_BOTH 2'h3

`define TCC_CNT_MAX 16'hFFFF
`define TCC_CNT_ZERO 16'h0000
`define TCC_RST_REG 16'h0000

`endif

/* File: src/tcc_edge_det.v */
// two-sample noise filter and valid-edge detector for one trigger input
`timescale 1ns/1ps
`include "tcc_regs.vh"

module tcc_edge_det
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire sample,
    input wire run,
    input wire [1:0] edge_sel,
    // pin
    input wire din,
    // results
    output reg valid_r,
    output reg rev_r
);

    reg smp_r;
    reg filt_r;
    reg armed_r;
    wire settle;
    wire rise;
    wire fall;

    function sel_ok;
        input [1:0] sel;
        input rising;
        begin
            sel_ok = (sel == `TCC_EDGE_BOTH) || (rising ? sel == `TCC_EDGE_RISE : sel == `TCC_EDGE_FALL);
        end
    endfunction

    // new level seen on two consecutive samples
    assign settle = sample && (din == smp_r) && (din != filt_r); // [R12]
    assign rise = settle && din;
    assign fall = settle && !din;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            smp_r <= 1'b0;
            filt_r <= 1'b0;
            armed_r <= 1'b0;
            valid_r <= 1'b0;
            rev_r <= 1'b0;
        end
        else
        begin
            valid_r <= 1'b0;
            rev_r <= 1'b0;
            if (run)
                armed_r <= 1'b1;
            if (sample && (run || armed_r))
                smp_r <= din;
            // level low since reset, so a high pin at first enable reads as a rise
            if (settle && (run || armed_r))
                filt_r <= din; // [R9] [R10]
            if (run)
            begin
                // stopped timer reports nothing
                valid_r <= (rise && sel_ok(edge_sel, 1'b1)) || (fall && sel_ok(edge_sel, 1'b0)); // [R13] [R12]
                rev_r <= (rise && edge_sel == `TCC_EDGE_FALL) || (fall && edge_sel == `TCC_EDGE_RISE);
            end
        end
    end

endmodule

/* File: src/tcc_top.v */
// 16-bit timer/event counter channel with two capture/compare registers and APB access
//
// Contract
// R1: overflow clear before counter reaches 0001H is cancelled; flag set again.
// R2: one-shot output in free-run and edge-clear modes, never in match-clear mode.
// R3: capture by input A is wrong when input A edge is the count clock.
// R4: trigger pulses must last longer than two prescaled count clocks.
// R5: capture on count clock falling edge; interrupt at following rising edge.
// R6: reverse-phase capture into register A raises no interrupt A.
// R7: reverse-phase mode: input B edge skips capture A but raises interrupt A.
// R8: software should mask interrupt A if that external interrupt is unwanted.
// R9: high input at first enable after reset counts as rising edge.
// R10: high input at a later re-enable is no rising edge; code sees a rise made while stopped if prescaler-sampled at div_sel_r not 0.
// R11: input A sampled on pclk as count clock, prescaled clock as trigger.
// R12: valid edge needs new level on two consecutive samples.
// R13: trigger inputs ignored while the counter is stopped.
// R14: overflow flag set on overflow and on FFFFH match-clear to 0000H.
// R15: edge of input A selected only while mode is stop.
// R16: counter and capture/compare registers are 16 bits wide.
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tcc_regs.vh"

module tcc_top
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // trigger pins
    input wire trigger_input_a,
    input wire trigger_input_b,
    // timer outputs
    output reg interrupt_a,
    output reg interrupt_b,
    output reg timer_out
);

    // software registers
    reg [1:0] mode_r;
    reg os_en_r;
    reg [1:0] div_sel_r;
    reg ext_clk_r;
    reg [2:0] crc_r;
    reg [3:0] edge_r;
    // counter state
    reg [15:0] sixteen_bit_counter;
    reg [15:0] capture_compare_reg_a;
    reg [15:0] capture_compare_reg_b;
    reg overflow_flag;
    reg ovf_win_r;
    reg [2:0] pre_r;
    reg os_arm_r;
    // capture pipeline
    reg cap_req_a_r;
    reg cap_req_b_r;
    reg irq_req_a_r;
    reg irq_req_b_r;
    reg irq_pend_a_r;
    reg irq_pend_b_r;

    wire run;
    wire [2:0] pre_max;
    wire rise_tick;
    wire fall_tick;
    wire edge_a;
    wire rev_a;
    wire edge_b;
    wire cnt_tick;
    wire match_a;
    wire match_b;
    wire ovf_evt;
    wire access;
    wire wr;
    wire sw_ovf_clr;
    wire os_trig;
    reg [31:0] rd_nxt;
    reg dec_ok;

    function hit;
        input [11:0] addr;
        input [11:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    assign run = (mode_r != `TCC_MODE_STOP);
    assign pre_max = (3'h1 << div_sel_r) - 3'h1;
    // prescaled count clock: rising edge closes the period, falling edge at mid period
    assign rise_tick = (pre_r == pre_max);
    assign fall_tick = (div_sel_r == 2'h0) || (pre_r == (pre_max >> 1));

    tcc_edge_det u_edge_a
    (
        .pclk(pclk),
        .presetn(presetn),
        .sample(ext_clk_r ? 1'b1 : rise_tick), // [R11]
        .run(run),
        .edge_sel(edge_r[`TCC_EDGE_A_LSB +: 2]),
        .din(trigger_input_a),
        .valid_r(edge_a),
        .rev_r(rev_a)
    );

    tcc_edge_det u_edge_b
    (
        .pclk(pclk),
        .presetn(presetn),
        .sample(rise_tick),
        .run(run),
        .edge_sel(edge_r[`TCC_EDGE_B_LSB +: 2]),
        .din(trigger_input_b),
        .valid_r(edge_b),
        .rev_r()
    );

    assign cnt_tick = run && (ext_clk_r ? edge_a : rise_tick);
    assign match_a = cnt_tick && (sixteen_bit_counter == capture_compare_reg_a);
    assign match_b = cnt_tick && (sixteen_bit_counter == capture_compare_reg_b);
    // wrap from FFFFH, whether by overflow or by an FFFFH match clear
    assign ovf_evt = cnt_tick && (sixteen_bit_counter == `TCC_CNT_MAX); // [R14]

    assign access = psel && penable && pready;
    assign wr = access && pwrite && dec_ok;
    assign sw_ovf_clr = wr && hit(paddr, `TCC_OFF_STAT) && pwdata[`TCC_STAT_OVF];
    assign os_trig = (wr && hit(paddr, `TCC_OFF_CTRL) && pwdata[`TCC_CTRL_OS_TRIG])
        || (mode_r == `TCC_MODE_EDGE_CLR && edge_a && !ext_clk_r);

    // read mux and address decode
    always @*
    begin
        rd_nxt = 32'h00000000;
        dec_ok = 1'b1;
        case (paddr)
            `TCC_OFF_CTRL: rd_nxt = {29'h0, os_en_r, mode_r};
            `TCC_OFF_PRM: rd_nxt = {29'h0, ext_clk_r, div_sel_r};
            `TCC_OFF_CRC: rd_nxt = {29'h0, crc_r};
            `TCC_OFF_EDGE: rd_nxt = {28'h0, edge_r};
            `TCC_OFF_STAT: rd_nxt = {29'h0, run, timer_out, overflow_flag};
            `TCC_OFF_CNT: rd_nxt = {16'h0, sixteen_bit_counter};
            `TCC_OFF_CCA: rd_nxt = {16'h0, capture_compare_reg_a};
            `TCC_OFF_CCB: rd_nxt = {16'h0, capture_compare_reg_b};
            default: dec_ok = 1'b0;
        endcase
    end

    // apb slave: one wait state, data and error registered with pready
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !dec_ok;
            if (psel && penable && !pready && !pwrite)
                prdata <= rd_nxt;
        end
    end

    // control registers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= `TCC_MODE_STOP;
            os_en_r <= 1'b0;
            div_sel_r <= 2'h0;
            ext_clk_r <= 1'b0;
            crc_r <= 3'h0;
            edge_r <= {`TCC_EDGE_FALL, `TCC_EDGE_FALL};
        end
        else if (wr)
        begin
            if (hit(paddr, `TCC_OFF_CTRL))
            begin
                mode_r <= pwdata[`TCC_CTRL_MODE_LSB +: 2];
                os_en_r <= pwdata[`TCC_CTRL_OS_EN];
            end
            if (hit(paddr, `TCC_OFF_PRM))
            begin
                div_sel_r <= pwdata[`TCC_PRM_DIV_LSB +: 2];
                ext_clk_r <= pwdata[`TCC_PRM_EXT];
            end
            if (hit(paddr, `TCC_OFF_CRC))
                crc_r <= pwdata[2:0];
            // edges only take effect while stopped
            if (hit(paddr, `TCC_OFF_EDGE) && !run)
                edge_r <= pwdata[3:0]; // [R15]
        end
    end

    // prescaler and counter
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_r <= 3'h0;
            sixteen_bit_counter <= `TCC_CNT_ZERO;
        end
        else if (!run)
        begin
            pre_r <= 3'h0;
            sixteen_bit_counter <= `TCC_CNT_ZERO;
        end
        else
        begin
            pre_r <= rise_tick ? 3'h0 : pre_r + 3'h1;
            if (mode_r == `TCC_MODE_EDGE_CLR && edge_a && !ext_clk_r)
                sixteen_bit_counter <= `TCC_CNT_ZERO;
            else if (mode_r == `TCC_MODE_MATCH_CLR && match_a)
                sixteen_bit_counter <= `TCC_CNT_ZERO;
            else if (cnt_tick)
                sixteen_bit_counter <= sixteen_bit_counter + 16'h0001; // [R16]
        end
    end

    // overflow flag; a clear while the counter still sits at 0000H is undone
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overflow_flag <= 1'b0;
            ovf_win_r <= 1'b0;
        end
        else
        begin
            if (ovf_evt)
                ovf_win_r <= 1'b1;
            else if (cnt_tick || !run)
                ovf_win_r <= 1'b0;
            if (ovf_evt || (ovf_win_r && !cnt_tick && run)) // [R1] [R14]
                overflow_flag <= 1'b1;
            else if (sw_ovf_clr)
                overflow_flag <= 1'b0;
        end
    end

    // capture requests, latch at count clock falling edge, interrupt at next rising edge
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            capture_compare_reg_a <= `TCC_RST_REG;
            capture_compare_reg_b <= `TCC_RST_REG;
            cap_req_a_r <= 1'b0;
            cap_req_b_r <= 1'b0;
            irq_req_a_r <= 1'b0;
            irq_req_b_r <= 1'b0;
            irq_pend_a_r <= 1'b0;
            irq_pend_b_r <= 1'b0;
        end
        else if (!run)
        begin
            cap_req_a_r <= 1'b0;
            cap_req_b_r <= 1'b0;
            irq_req_a_r <= 1'b0;
            irq_req_b_r <= 1'b0;
            irq_pend_a_r <= 1'b0;
            irq_pend_b_r <= 1'b0;
            if (wr && hit(paddr, `TCC_OFF_CCA))
                capture_compare_reg_a <= pwdata[15:0];
            if (wr && hit(paddr, `TCC_OFF_CCB))
                capture_compare_reg_b <= pwdata[15:0];
        end
        else
        begin
            if (fall_tick) // [R5]
            begin
                if (cap_req_a_r)
                    capture_compare_reg_a <= sixteen_bit_counter;
                if (cap_req_b_r)
                    capture_compare_reg_b <= sixteen_bit_counter;
                cap_req_a_r <= 1'b0;
                cap_req_b_r <= 1'b0;
                irq_req_a_r <= 1'b0;
                irq_req_b_r <= 1'b0;
                irq_pend_a_r <= irq_req_a_r || (irq_pend_a_r && !rise_tick);
                irq_pend_b_r <= irq_req_b_r || (irq_pend_b_r && !rise_tick);
            end
            else if (rise_tick)
            begin
                irq_pend_a_r <= 1'b0;
                irq_pend_b_r <= 1'b0;
            end
            if (crc_r[`TCC_CRC_CAP_A])
            begin
                if (crc_r[`TCC_CRC_REV])
                begin
                    // opposite edge of input A captures silently
                    if (rev_a)
                        cap_req_a_r <= 1'b1; // [R6]
                    // input B only raises the external interrupt
                    if (edge_b)
                        irq_req_a_r <= 1'b1; // [R7]
                end
                else if (edge_b)
                begin
                    cap_req_a_r <= 1'b1;
                    irq_req_a_r <= 1'b1;
                end
            end
            if (crc_r[`TCC_CRC_CAP_B] && edge_a)
            begin
                cap_req_b_r <= 1'b1;
                irq_req_b_r <= 1'b1;
            end
            if (wr && hit(paddr, `TCC_OFF_CCA) && !crc_r[`TCC_CRC_CAP_A] && !cap_req_a_r)
                capture_compare_reg_a <= pwdata[15:0];
            if (wr && hit(paddr, `TCC_OFF_CCB) && !crc_r[`TCC_CRC_CAP_B] && !cap_req_b_r)
                capture_compare_reg_b <= pwdata[15:0];
        end
    end

    // interrupt pulses and one-shot output
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            interrupt_a <= 1'b0;
            interrupt_b <= 1'b0;
            timer_out <= 1'b0;
            os_arm_r <= 1'b0;
        end
        else
        begin
            interrupt_a <= (rise_tick && irq_pend_a_r && !(fall_tick && div_sel_r != 2'h0)) // [R5]
                || (match_a && !crc_r[`TCC_CRC_CAP_A]);
            interrupt_b <= (rise_tick && irq_pend_b_r) || (match_b && !crc_r[`TCC_CRC_CAP_B]);
            if (!run || !os_en_r || mode_r == `TCC_MODE_MATCH_CLR) // [R2]
            begin
                os_arm_r <= 1'b0;
                timer_out <= 1'b0;
            end
            else
            begin
                if (os_trig)
                    os_arm_r <= 1'b1;
                if (os_arm_r && match_b)
                    timer_out <= 1'b1;
                if (os_arm_r && match_a && timer_out)
                begin
                    timer_out <= 1'b0;
                    os_arm_r <= 1'b0;
                end
            end
        end
    end

endmodule

/* File: sim/tcc_assertions.sv */
// port-level checker for the timer channel
`timescale 1ns/1ps
`include "tcc_regs.vh"
module tcc_chk
(
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins
    input wire trigger_input_a,
    input wire trigger_input_b,
    input wire interrupt_a,
    input wire interrupt_b,
    input wire timer_out
);
    reg [1:0] mode_r;
    reg [2:0] crc_r;
    reg [4:0] stop_r;
    reg [5:0] qa_r;
    reg [5:0] qb_r;
    reg a_d;
    reg b_d;
    wire wr_done;
    wire ctl_wr;
    assign wr_done = psel && penable && pready && pwrite && !pslverr;
    assign ctl_wr = wr_done && paddr == `TCC_OFF_CTRL;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // shadow mode and capture control; cycles since each pin moved or the control register was written
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_r <= 2'h0;
            crc_r <= 3'h0;
            stop_r <= 5'h00;
            qa_r <= 6'h3F;
            qb_r <= 6'h3F;
            a_d <= 1'b0;
            b_d <= 1'b0;
        end
        else
        begin
            if (ctl_wr)
                mode_r <= pwdata[1:0];
            if (wr_done && paddr == `TCC_OFF_CRC)
                crc_r <= pwdata[2:0];
            a_d <= trigger_input_a;
            b_d <= trigger_input_b;
            stop_r <= (mode_r != 2'h0) ? 5'h00 : stop_r + {4'h0, stop_r != 5'h1F};
            qa_r <= (ctl_wr || trigger_input_a != a_d) ? 6'h00 : qa_r + {5'h00, qa_r != 6'h3F};
            qb_r <= (ctl_wr || trigger_input_b != b_d) ? 6'h00 : qb_r + {5'h00, qb_r != 6'h3F};
        end
    end
    property p_rdy_wait;
        psel && $rose(penable) |=> pready;
    endproperty
    a_rdy_wait: assert property (p_rdy_wait) else $error("pready late");
    property p_rdy_acc;
        pready |-> psel && penable && $past(penable);
    endproperty
    a_rdy_acc: assert property (p_rdy_acc) else $error("pready outside access");
    property p_err_map;
        pready |-> pslverr == (paddr > `TCC_OFF_CCB);
    endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr wrong");
    property p_int_pulse;
        interrupt_a |=> !interrupt_a;
    endproperty
    a_int_pulse: assert property (p_int_pulse) else $error("interrupt_a too long");
    property p_stop_quiet;
        stop_r == 5'h1F |-> !interrupt_a && !interrupt_b && !$rose(timer_out);
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("activity while stopped");
    property p_no_oneshot;
        mode_r == `TCC_MODE_MATCH_CLR && $past(mode_r) == `TCC_MODE_MATCH_CLR |-> !$rose(timer_out);
    endproperty
    a_no_oneshot: assert property (p_no_oneshot) else $error("one-shot in match mode");
    property p_cap_int_b;
        interrupt_b && mode_r == `TCC_MODE_FREE && crc_r[2] |-> qa_r < 6'h30;
    endproperty
    a_cap_int_b: assert property (p_cap_int_b) else $error("interrupt_b without a edge");
    property p_rev_int_a;
        interrupt_a && mode_r == `TCC_MODE_FREE && crc_r[1] |-> qb_r < 6'h30;
    endproperty
    a_rev_int_a: assert property (p_rev_int_a) else $error("interrupt_a without b edge");
    c_int_a: cover property ($rose(interrupt_a));
    c_err: cover property (pslverr);
    c_out: cover property ($rose(timer_out));
endmodule

bind tcc_top tcc_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_input_a(trigger_input_a), .trigger_input_b(trigger_input_b), .interrupt_a(interrupt_a),
    .interrupt_b(interrupt_b), .timer_out(timer_out));

/* File: sim/tcc_trig_drv.sv */
// event source model driving the two trigger pins
`timescale 1ns/1ps
module tcc_trig_drv
(
    // clock
    input wire pclk,
    // trigger pins
    output wire trig_a,
    output wire trig_b
);
    reg [1:0] pin_r = 2'b00;
    assign trig_a = pin_r[0];
    assign trig_b = pin_r[1];
    task level(input sel, input v);
    begin
        @(posedge pclk);
        pin_r[sel] <= v;
    end
    endtask
    // high for hi cycles, then low for hi cycles
    task pulse(input sel, input integer hi);
    begin
        level(sel, 1'b1);
        repeat (hi) @(posedge pclk);
        pin_r[sel] <= 1'b0;
        repeat (hi) @(posedge pclk);
    end
    endtask
endmodule

/* File: sim/tb_top.sv */
// self-checking bench for the timer channel
`timescale 1ns/1ps
`include "tcc_regs.vh"
module tb_top;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, trg_a, trg_b, int_a, int_b, t_out;
    integer bad_count = 0;
    integer n_checks = 0;
    integer i, m, hits_a, hits_b, hits_o;
    reg [31:0] rd, c0;
    reg [31:0] seed = 32'h9;
    reg err;
    always #2.5 pclk = ~pclk;
    tcc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trigger_input_a(trg_a), .trigger_input_b(trg_b), .interrupt_a(int_a), .interrupt_b(int_b),
        .timer_out(t_out));
    tcc_trig_drv i_trig (.pclk(pclk), .trig_a(trg_a), .trig_b(trg_b));
    function [31:0] xs(input [31:0] s);
    begin
        xs = s ^ (s << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    end
    endfunction
    task give_verdict;
    begin
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask
    task chk(input string what, input [31:0] exp, input [31:0] got);
    begin
        n_checks = n_checks + 1;
        if (got !== exp)
        begin
            bad_count = bad_count + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer t;
    begin
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && t < 16)
        begin
            t = t + 1;
            @(posedge pclk);
        end
        if (t == 16)
        begin
            bad_count = bad_count + 1;
            give_verdict;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    end
    endtask
    task watch(input integer n);
    begin
        hits_a = 0;
        hits_b = 0;
        hits_o = 0;
        repeat (n)
        begin
            @(posedge pclk);
            hits_a = hits_a + int_a;
            hits_b = hits_b + int_b;
            hits_o = hits_o + t_out;
        end
    end
    endtask
    // pulse a pin, stretched at random only when hi is over 3, while watching the outputs
    task pw(input sel, input integer hi, input integer n);
    begin
        seed = xs(seed);
        fork
            i_trig.pulse(sel, hi > 3 ? hi + seed[1:0] : hi);
            watch(n);
        join
    end
    endtask
    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `TCC_OFF_STAT, 0);
        chk("stat", 0, rd);
        apb(0, 12'h020, 0);
        chk("slverr", 1, err);
        for (i = 0; i < 4; i = i + 1)
        begin
            seed = xs(seed);
            apb(1, `TCC_OFF_CCB, seed);
            apb(0, `TCC_OFF_CCB, 0);
            chk("ccb", {16'h0000, seed[15:0]}, rd);
        end
        i_trig.level(0, 1'b1);
        apb(1, `TCC_OFF_EDGE, 1);
        apb(1, `TCC_OFF_CRC, 4);
        apb(1, `TCC_OFF_CTRL, `TCC_MODE_FREE);
        watch(40);
        chk("first run rise", 1, hits_b);
        apb(1, `TCC_OFF_CTRL, 0);
        pw(0, 6, 30);
        chk("stopped edge", 0, hits_b);
        i_trig.level(0, 1'b1);
        apb(1, `TCC_OFF_CTRL, `TCC_MODE_FREE);
        watch(40);
        chk("rerun rise", 0, hits_b);
        for (i = 0; i < 2; i = i + 1)
        begin
            apb(1, `TCC_OFF_CTRL, 0);
            i_trig.level(0, 1'b0);
            apb(1, `TCC_OFF_PRM, 3 * i);
            apb(1, `TCC_OFF_CTRL, `TCC_MODE_FREE);
            pw(0, i ? 3 : 1, 80);
            chk("glitch", 0, hits_b);
            pw(0, i ? 25 : 4, 100);
            chk("capture", 1, hits_b);
        end
        apb(1, `TCC_OFF_CTRL, 0);
        apb(1, `TCC_OFF_PRM, 0);
        apb(1, `TCC_OFF_EDGE, 5);
        apb(1, `TCC_OFF_CRC, 3);
        apb(1, `TCC_OFF_CTRL, `TCC_MODE_FREE);
        apb(0, `TCC_OFF_CCA, 0);
        c0 = rd;
        pw(0, 4, 40);
        chk("reverse int", 0, hits_a);
        apb(0, `TCC_OFF_CCA, 0);
        chk("reverse cap", 1, rd != c0);
        c0 = rd;
        pw(1, 4, 40);
        chk("b int", 1, hits_a);
        apb(0, `TCC_OFF_CCA, 0);
        chk("b no cap", c0, rd);
        apb(1, `TCC_OFF_CTRL, 0);
        apb(1, `TCC_OFF_CRC, 0);
        apb(1, `TCC_OFF_CCA, 32'h40);
        apb(1, `TCC_OFF_CCB, 32'h20);
        for (m = 1; m < 4; m = m + 1)
        begin
            apb(1, `TCC_OFF_CTRL, 0);
            apb(1, `TCC_OFF_CTRL, m + 4);
            apb(1, `TCC_OFF_CTRL, m + 12);
            watch(200);
            chk("one-shot", m != 3, hits_o > 0);
        end
        apb(1, `TCC_OFF_CTRL, 0);
        apb(1, `TCC_OFF_CCA, 32'hFFFF);
        apb(1, `TCC_OFF_CTRL, `TCC_MODE_MATCH_CLR);
        rd = 0;
        for (i = 0; i < 20000 && rd < 32'hFFF0; i = i + 1)
            apb(0, `TCC_OFF_CNT, 0);
        chk("poll", 1, i < 20000);
        // count on input edges; input is not a capture trigger here
        apb(1, `TCC_OFF_PRM, 4);
        apb(0, `TCC_OFF_CNT, 0);
        for (i = rd; i <= 32'hFFFF; i = i + 1)
            pw(0, 4, 0);
        apb(0, `TCC_OFF_STAT, 0);
        chk("ovf", 1, rd[0]);
        apb(1, `TCC_OFF_STAT, 1);
        pw(0, 4, 0);
        apb(0, `TCC_OFF_STAT, 0);
        chk("early clear", 1, rd[0]);
        apb(1, `TCC_OFF_STAT, 1);
        apb(0, `TCC_OFF_STAT, 0);
        chk("late clear", 0, rd[0]);
        apb(0, `TCC_OFF_CNT, 0);
        chk("cnt", 1, rd);
        give_verdict;
    end
endmodule
